// File: lpc_device.sv
`timescale 1ns/10ps
// Summary of operation
// (RULE1) 8-bit duty per channel, 256 levels
// (RULE2) duty bits binary weighted, average is duty/256
// (RULE3) duty registers at 05h..20h in channel order
// (RULE4) duty and control writes go to holding copies
// (RULE5) zero byte at 25h commits all held values
// (RULE6) control at 2Ah..45h: on bit, scale field
// (RULE7) scale code selects full, half, third, quarter
// (RULE8) channel off bit forces output off
// (RULE9) global bit at 4Ah forces all off
// (RULE10) 4Bh bit selects 3kHz or 22kHz
// (RULE11) zero byte at 4Fh resets all registers
// (RULE12) power-up reset clears everything to zero
// (RULE13) host may step duty along gamma curve
// (RULE14) host picks 32 or 64 gamma steps
// (RULE15) soft shutdown bit zero turns outputs off
// (RULE16) shutdown pin low turns outputs off
// (RULE17) register pointer increments after each data byte
// (RULE18) global bit one means outputs forced off
// (RULE19) shared counter below duty drives output on
module lpc_device #(
    parameter int NUM_CH = lpc_pkg::NUM_CH,
    parameter int DIV_SLOW = lpc_pkg::DIV_SLOW,
    parameter int DIV_FAST = lpc_pkg::DIV_FAST
) (
    input wire logic i_clk,
    input wire logic i_srst,
    lpc_link_if.device link,
    output logic [NUM_CH-1:0] o_led_outputs,
    output logic [2*NUM_CH-1:0] o_current_scale
);
    function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                      input logic [7:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // both trigger registers act only on the all-zero byte
    function automatic logic trigger_hit(input logic [7:0] a, input logic [7:0] at,
                                         input logic [7:0] d);
        trigger_hit = (a == at) && (d == lpc_pkg::TRIGGER_VALUE);
    endfunction : trigger_hit

    logic [7:0] ptr_q;
    logic ack_q;
    logic soft_shutdown_n_q;
    logic global_off_q;
    logic pwm_freq_select_q;
    logic [7:0] div_q;
    logic [7:0] pwm_cnt_q;
    logic pin_meta_q;
    logic pin_sync_q;
    logic [NUM_CH-1:0] led_q;
    logic [2*NUM_CH-1:0] scale_q;
    wire [NUM_CH-1:0] led_d;
    wire [2*NUM_CH-1:0] scale_d;

    wire data_wr = link.byte_vld && !link.byte_first;
    wire [7:0] wdata = link.byte_data;
    wire wr_duty = data_wr && in_range(ptr_q, lpc_pkg::ADDR_DUTY_FIRST,
                                       lpc_pkg::ADDR_DUTY_LAST);
    wire wr_ctl = data_wr && in_range(ptr_q, lpc_pkg::ADDR_CTL_FIRST,
                                      lpc_pkg::ADDR_CTL_LAST);
    wire commit = data_wr && trigger_hit(ptr_q, lpc_pkg::ADDR_COMMIT, wdata); // RULE5
    // the all-zero byte at the reset register clears the mapped registers; the pointer, pin sync and pwm counters are left running
    wire soft_rst = data_wr && trigger_hit(ptr_q, lpc_pkg::ADDR_RESET, wdata); // RULE11
    wire wr_shutdown = data_wr && (ptr_q == lpc_pkg::ADDR_SHUTDOWN);
    wire wr_global = data_wr && (ptr_q == lpc_pkg::ADDR_GLOBAL);
    wire wr_freq = data_wr && (ptr_q == lpc_pkg::ADDR_FREQ);
    wire ptr_load = link.byte_vld && link.byte_first;
    wire clr = i_srst || soft_rst; // RULE12
    wire [7:0] duty_idx = ptr_q - lpc_pkg::ADDR_DUTY_FIRST; // RULE3
    wire [7:0] ctl_idx = ptr_q - lpc_pkg::ADDR_CTL_FIRST; // RULE6
    wire [7:0] div_top = pwm_freq_select_q ? 8'(DIV_FAST - 1) : 8'(DIV_SLOW - 1);
    // a switch to the faster rate mid-step can leave the divider above its new top
    wire pwm_tick = (div_q >= div_top);
    // shutdown pin, soft shutdown and global off all gate every channel together
    wire out_enable = soft_shutdown_n_q && pin_sync_q && !global_off_q;

    // the pointer is a link-side state, not a register, so the reset byte leaves it alone
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ptr_q <= 8'h00;
        end else if (ptr_load) begin
            ptr_q <= wdata;
        end else if (data_wr) begin
            ptr_q <= ptr_q + 8'h01; // RULE17
        end
    end

    // one-cycle acknowledge; the host holds off its next byte until it sees it
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= link.byte_vld;
        end
    end

    // shutdown, global and rate bits are live at once; they have no holding copy
    always_ff @(posedge i_clk) begin
        if (clr) begin
            soft_shutdown_n_q <= 1'b0;
        end else if (wr_shutdown) begin
            soft_shutdown_n_q <= wdata[lpc_pkg::BIT_FLAG]; // RULE15
        end
    end

    always_ff @(posedge i_clk) begin
        if (clr) begin
            global_off_q <= 1'b0;
        end else if (wr_global) begin
            global_off_q <= wdata[lpc_pkg::BIT_FLAG]; // RULE9 RULE18
        end
    end

    always_ff @(posedge i_clk) begin
        if (clr) begin
            pwm_freq_select_q <= 1'b0;
        end else if (wr_freq) begin
            pwm_freq_select_q <= wdata[lpc_pkg::BIT_FLAG]; // RULE10
        end
    end

    // the pin is asynchronous to this clock
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
        end else begin
            pin_meta_q <= link.hw_shutdown_pin_n;
            pin_sync_q <= pin_meta_q; // RULE16
        end
    end

    // divider gives one tick per pwm step; 256 steps make one period
    always_ff @(posedge i_clk) begin
        if (i_srst || pwm_tick) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pwm_cnt_q <= 8'h00;
        end else if (pwm_tick) begin
            pwm_cnt_q <= pwm_cnt_q + 8'h01; // RULE19
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            logic [7:0] duty_hold_q;
            logic [7:0] duty_act_q;
            logic [2:0] ctl_hold_q;
            logic [2:0] ctl_act_q;
            wire sel_duty = wr_duty && (duty_idx == 8'(ch));
            wire sel_ctl = wr_ctl && (ctl_idx == 8'(ch));

            // holding copies take every write; the outputs see none of it before a commit
            always_ff @(posedge i_clk) begin
                if (clr) begin
                    duty_hold_q <= lpc_pkg::REG_RESET_VAL;
                    ctl_hold_q <= 3'h0;
                end else begin
                    if (sel_duty) begin
                        duty_hold_q <= wdata; // RULE1 RULE4
                    end
                    if (sel_ctl) begin
                        ctl_hold_q <= wdata[lpc_pkg::BIT_SCALE_HI:lpc_pkg::BIT_ON]; // RULE4
                    end
                end
            end

            // a commit moves every channel on one edge, so no half-updated frame shows
            always_ff @(posedge i_clk) begin
                if (clr) begin
                    duty_act_q <= lpc_pkg::REG_RESET_VAL;
                    ctl_act_q <= 3'h0;
                end else if (commit) begin
                    duty_act_q <= duty_hold_q; // RULE5
                    ctl_act_q <= ctl_hold_q;
                end
            end

            // counter below duty: duty 0 never on, duty n on n of 256 steps
            assign led_d[ch] = out_enable && ctl_act_q[lpc_pkg::BIT_ON]
                               && (pwm_cnt_q < duty_act_q); // RULE2 RULE8 RULE19
            assign scale_d[2*ch +: 2] = ctl_act_q[lpc_pkg::BIT_SCALE_HI:
                                                  lpc_pkg::BIT_SCALE_LO]; // RULE7
        end
    endgenerate

    // all channels share one counter, so every output switches on the same edge
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            led_q <= '0;
            scale_q <= '0;
        end else begin
            led_q <= led_d;
            scale_q <= scale_d;
        end
    end

    assign link.byte_ack = ack_q;
    assign o_led_outputs = led_q;
    assign o_current_scale = scale_q;
endmodule : lpc_device

// File: lpc_pkg.sv
package lpc_pkg;
    localparam int NUM_CH = 28;
    localparam int CLK_HZ = 50000000;
    localparam int PWM_STEPS = 256;
    localparam int PWM_SLOW_HZ = 3000;
    localparam int PWM_FAST_HZ = 22000;
    localparam int DIV_SLOW = CLK_HZ / (PWM_SLOW_HZ * PWM_STEPS);
    localparam int DIV_FAST = CLK_HZ / (PWM_FAST_HZ * PWM_STEPS);
    // device register map
    localparam logic [7:0] ADDR_SHUTDOWN = 8'h00;
    localparam logic [7:0] ADDR_DUTY_FIRST = 8'h05;
    localparam logic [7:0] ADDR_DUTY_LAST = 8'h20;
    localparam logic [7:0] ADDR_COMMIT = 8'h25;
    localparam logic [7:0] ADDR_CTL_FIRST = 8'h2A;
    localparam logic [7:0] ADDR_CTL_LAST = 8'h45;
    localparam logic [7:0] ADDR_GLOBAL = 8'h4A;
    localparam logic [7:0] ADDR_FREQ = 8'h4B;
    localparam logic [7:0] ADDR_RESET = 8'h4F;
    localparam logic [7:0] TRIGGER_VALUE = 8'h00;
    localparam logic [7:0] REG_RESET_VAL = 8'h00;
    localparam int BIT_ON = 0;
    localparam int BIT_SCALE_LO = 1;
    localparam int BIT_SCALE_HI = 2;
    localparam int BIT_FLAG = 0;
    // host command registers
    localparam logic [1:0] HREG_TARGET = 2'h0;
    localparam logic [1:0] HREG_DATA = 2'h1;
    localparam logic [1:0] HREG_STATUS = 2'h2;
    localparam logic [1:0] HREG_PIN = 2'h3;
    localparam int HSTAT_BUSY = 0;
    localparam int HSTAT_ADDR_PEND = 1;
endpackage : lpc_pkg

// File: lpc_link_if.sv
`timescale 1ns/10ps
interface lpc_link_if;
    logic byte_vld;
    logic byte_first;
    logic [7:0] byte_data;
    logic byte_ack;
    logic hw_shutdown_pin_n;
    modport device (input byte_vld, input byte_first, input byte_data,
                    input hw_shutdown_pin_n, output byte_ack);
    modport host (output byte_vld, output byte_first, output byte_data,
                  output hw_shutdown_pin_n, input byte_ack);
endinterface : lpc_link_if

// File: lpc_host.sv
`timescale 1ns/10ps
module lpc_host (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    lpc_link_if.host link
);
    typedef enum logic [2:0] {
        LPC_H_IDLE, LPC_H_ADDR, LPC_H_ADDR_WAIT, LPC_H_DATA, LPC_H_DATA_WAIT
    } lpc_hstate_t;

    lpc_hstate_t state_q;
    logic [7:0] target_q;
    logic [7:0] data_q;
    logic addr_pend_q;
    logic pin_q;
    logic [7:0] rdata_q;
    logic vld_q;
    logic first_q;
    logic [7:0] byte_q;

    wire busy = (state_q != LPC_H_IDLE);
    wire wr_target = i_wr && (i_addr == lpc_pkg::HREG_TARGET) && !busy;
    wire wr_data = i_wr && (i_addr == lpc_pkg::HREG_DATA) && !busy;
    wire wr_pin = i_wr && (i_addr == lpc_pkg::HREG_PIN);
    wire [7:0] status_word = {6'h00, addr_pend_q, busy};
    wire [7:0] read_mux = (i_addr == lpc_pkg::HREG_TARGET) ? target_q :
                          (i_addr == lpc_pkg::HREG_DATA) ? data_q :
                          (i_addr == lpc_pkg::HREG_STATUS) ? status_word :
                          {7'h00, pin_q};

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rdata_q <= 8'h00;
        end else if (i_rd) begin
            rdata_q <= read_mux;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pin_q <= 1'b0;
        end else if (wr_pin) begin
            pin_q <= i_wdata[lpc_pkg::BIT_FLAG];
        end
    end

    // a new target starts a fresh transfer; later data writes ride the auto increment
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_q <= LPC_H_IDLE;
            target_q <= 8'h00;
            data_q <= 8'h00;
            addr_pend_q <= 1'b0;
            vld_q <= 1'b0;
            first_q <= 1'b0;
            byte_q <= 8'h00;
        end else begin
            vld_q <= 1'b0;
            case (state_q)
                LPC_H_IDLE: begin
                    if (wr_target) begin
                        target_q <= i_wdata;
                        addr_pend_q <= 1'b1;
                    end else if (wr_data) begin
                        data_q <= i_wdata;
                        state_q <= addr_pend_q ? LPC_H_ADDR : LPC_H_DATA;
                    end
                end
                LPC_H_ADDR: begin
                    vld_q <= 1'b1;
                    first_q <= 1'b1;
                    byte_q <= target_q;
                    state_q <= LPC_H_ADDR_WAIT;
                end
                LPC_H_ADDR_WAIT: begin
                    if (link.byte_ack) begin
                        addr_pend_q <= 1'b0;
                        state_q <= LPC_H_DATA;
                    end
                end
                LPC_H_DATA: begin
                    vld_q <= 1'b1;
                    first_q <= 1'b0;
                    byte_q <= data_q;
                    state_q <= LPC_H_DATA_WAIT;
                end
                LPC_H_DATA_WAIT: begin
                    if (link.byte_ack) begin
                        state_q <= LPC_H_IDLE;
                    end
                end
                default: state_q <= LPC_H_IDLE;
            endcase
        end
    end

    assign o_rdata = rdata_q;
    assign link.byte_vld = vld_q;
    assign link.byte_first = first_q;
    assign link.byte_data = byte_q;
    assign link.hw_shutdown_pin_n = pin_q;
endmodule : lpc_host

// File: lpc_link_monitor.sv
`timescale 1ns/10ps
module lpc_link_monitor #(
    parameter int NUM_CH = 28
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic byte_vld,
    input wire logic byte_first,
    input wire logic [7:0] byte_data,
    input wire logic byte_ack,
    input wire logic hw_shutdown_pin_n,
    input wire logic [NUM_CH-1:0] o_led_outputs
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);
    a_ack_after_vld: assert property (byte_vld |=> byte_ack)
        else $error("byte not acknowledged one cycle later");
    a_ack_needs_vld: assert property (byte_ack |-> $past(byte_vld))
        else $error("acknowledge without a byte");
    a_ack_one_cycle: assert property (byte_ack |=> !byte_ack)
        else $error("acknowledge longer than one cycle");
    a_vld_spacing: assert property (byte_vld |=> !byte_vld ##1 !byte_vld)
        else $error("bytes closer than three cycles");
    a_data_hold: assert property (byte_ack |-> $stable(byte_data) && $stable(byte_first))
        else $error("byte changed before acknowledge");
    a_reset_dark: assert property ($fell(i_srst) |-> o_led_outputs == '0)
        else $error("outputs lit right after reset");
    a_reset_idle: assert property ($fell(i_srst) |-> !byte_vld && !hw_shutdown_pin_n)
        else $error("link not idle after reset");
    // pin passes a two-stage sync, so four low samples must have reached the outputs
    a_pin_dark: assert property (!hw_shutdown_pin_n [*4] |-> o_led_outputs == '0)
        else $error("outputs lit while shutdown pin low");
endmodule : lpc_link_monitor

// File: led_pwm_channel_regs_tb.sv
`timescale 1ns/10ps
module led_pwm_channel_regs_tb;
    localparam int DS = 2;
    localparam int DF = 1;
    localparam int PS = 256 * (DS + 1);
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [27:0] leds;
    logic [55:0] scale;
    int err_count = 0;
    int num_checks = 0;
    int hi [28];
    int tot;
    lpc_link_if lnk ();
    lpc_host i_lpc_host (.i_clk(i_clk), .i_srst(i_srst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .link(lnk));
    // a pwm step lasts DS + 1 or DF + 1 clocks here, short enough to sweep whole periods
    lpc_device #(.DIV_SLOW(DS + 1), .DIV_FAST(DF + 1)) i_lpc_device (.i_clk(i_clk),
        .i_srst(i_srst), .link(lnk), .o_led_outputs(leds), .o_current_scale(scale));
    lpc_link_monitor #(.NUM_CH(28)) i_lpc_link_monitor (.i_clk(i_clk), .i_srst(i_srst),
        .byte_vld(lnk.byte_vld), .byte_first(lnk.byte_first), .byte_data(lnk.byte_data),
        .byte_ack(lnk.byte_ack), .hw_shutdown_pin_n(lnk.hw_shutdown_pin_n), .o_led_outputs(leds));
    always #10 i_clk = ~i_clk;
    function automatic logic [7:0] duty(input int k);
        return (k == 27) ? 8'hFF : 8'(k * 9);
    endfunction : duty
    function automatic logic [7:0] ctl(input int k);
        return 8'(((k % 4) << 1) | 1);
    endfunction : ctl
    task automatic chk(input bit ok, input string m);
        num_checks++;
        if (!ok) begin
            err_count++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask : chk
    task automatic hwr(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask : hwr
    // busy may lag the strobe, so polling starts late to avoid a dropped write
    task automatic dwr(input bit tg, input logic [7:0] r, input logic [7:0] d);
        bit idle;
        idle = 1'b0;
        if (tg)
            hwr(lpc_pkg::HREG_TARGET, r);
        hwr(lpc_pkg::HREG_DATA, d);
        repeat (3) @(posedge i_clk);
        for (int n = 0; n < 40; n++) begin
            @(posedge i_clk);
            addr <= lpc_pkg::HREG_STATUS;
            rd <= 1'b1;
            @(posedge i_clk);
            rd <= 1'b0;
            #1;
            if (rdata[lpc_pkg::HSTAT_BUSY] === 1'b0) begin
                idle = 1'b1;
                break;
            end
        end
        chk(idle, "host never went idle");
    endtask : dwr
    // a whole period at any phase gives the exact on-time count
    task automatic meas(input int n);
        tot = 0;
        hi = '{default: 0};
        repeat (8) @(posedge i_clk);
        repeat (n) begin
            @(negedge i_clk);
            for (int k = 0; k < 28; k++) begin
                hi[k] += (leds[k] === 1'b1);
                tot += (leds[k] === 1'b1);
            end
        end
    endtask : meas
    task automatic gate(input int g, input bit off);
        if (g == 0)
            dwr(1, lpc_pkg::ADDR_GLOBAL, {7'h00, off});
        else if (g == 1)
            dwr(1, lpc_pkg::ADDR_SHUTDOWN, {7'h00, !off});
        else
            hwr(lpc_pkg::HREG_PIN, {7'h00, !off});
    endtask : gate
    task automatic t_reset();
        meas(PS);
        chk(tot == 0 && scale === 56'h0, "dark after reset");
        $display("test reset done");
    endtask : t_reset
    task automatic t_load();
        hwr(lpc_pkg::HREG_PIN, 8'h01);
        dwr(1, lpc_pkg::ADDR_SHUTDOWN, 8'h01);
        for (int j = 0; j < 2; j++) begin
            for (int k = 0; k < 28; k++) begin
                dwr(k == 0, j ? lpc_pkg::ADDR_CTL_FIRST : lpc_pkg::ADDR_DUTY_FIRST, j ? ctl(k) : duty(k));
            end
        end
        meas(PS);
        chk(tot == 0, "outputs moved before commit");
        dwr(1, lpc_pkg::ADDR_COMMIT, 8'h01);
        meas(PS);
        chk(tot == 0, "nonzero commit taken");
        dwr(1, lpc_pkg::ADDR_COMMIT, lpc_pkg::TRIGGER_VALUE);
        meas(PS);
        for (int k = 0; k < 28; k++) begin
            chk(hi[k] == duty(k) * (DS + 1) && scale[2*k+:2] === 2'(k % 4), "duty or scale");
        end
        $display("test load done");
    endtask : t_load
    task automatic t_freq();
        dwr(1, lpc_pkg::ADDR_FREQ, 8'h01);
        meas(256 * (DF + 1));
        chk(hi[20] == duty(20) * (DF + 1), "fast rate");
        dwr(1, lpc_pkg::ADDR_FREQ, 8'h00);
        $display("test freq done");
    endtask : t_freq
    // levels taken from the 32- and 64-step breathing curves, stepped on channel 0
    task automatic t_gamma();
        int lv [4] = '{1, 22, 255, 73};
        for (int i = 0; i < 4; i++) begin
            dwr(1, lpc_pkg::ADDR_DUTY_FIRST, 8'(lv[i]));
            dwr(1, lpc_pkg::ADDR_COMMIT, lpc_pkg::TRIGGER_VALUE);
            meas(PS);
            chk(hi[0] == lv[i] * (DS + 1), "gamma level on-time");
        end
        $display("test gamma done");
    endtask : t_gamma
    task automatic t_gates();
        for (int g = 0; g < 3; g++) begin
            gate(g, 1'b1);
            meas(PS);
            chk(tot == 0, "gate left outputs lit");
            gate(g, 1'b0);
            meas(PS);
            chk(hi[20] == duty(20) * (DS + 1), "state lost across gate");
        end
        $display("test gates done");
    endtask : t_gates
    task automatic t_off();
        dwr(1, lpc_pkg::ADDR_CTL_FIRST + 8'd20, 8'h00);
        dwr(1, lpc_pkg::ADDR_COMMIT, 8'h00);
        meas(PS);
        chk(hi[20] == 0 && hi[21] == duty(21) * (DS + 1), "channel off bit");
        $display("test off done");
    endtask : t_off
    task automatic t_rst();
        dwr(1, lpc_pkg::ADDR_RESET, 8'h01);
        meas(PS);
        chk(hi[21] == duty(21) * (DS + 1), "nonzero reset taken");
        dwr(1, lpc_pkg::ADDR_RESET, 8'h00);
        meas(PS);
        chk(tot == 0 && scale === 56'h0, "registers not cleared");
        dwr(1, lpc_pkg::ADDR_SHUTDOWN, 8'h01);
        dwr(1, lpc_pkg::ADDR_COMMIT, 8'h00);
        meas(PS);
        chk(tot == 0, "holding copy survived");
        $display("test regreset done");
    endtask : t_rst
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report
    initial begin
        repeat (8) @(posedge i_clk);
        i_srst <= 1'b0;
        t_reset();
        t_load();
        t_freq();
        t_gamma();
        t_gates();
        t_off();
        t_rst();
        final_report();
    end
    initial begin
        #(60000 * 20);
        err_count++;
        final_report();
    end
endmodule : led_pwm_channel_regs_tb
